// File: logic/isra_host.sv
// Master end: bus controller that reads and writes the sensor registers
`timescale 1ns/100ps
module isra_host #(
	parameter logic        STRAP_HIGH  = 1'b1, // Strap level this board ties
	parameter logic        USE_RESTART = 1'b1, // Restart, else stop then start
	parameter int unsigned LW          = 4     // Width of the length field
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Bus pins
	isra_bus_if.host           bus,
	// Command request
	input  wire logic          cmd_valid,
	output logic               cmd_ready,
	input  wire logic          cmd_read,
	input  wire logic          cmd_fast,
	input  wire logic [7:0]    cmd_reg,
	input  wire logic [LW-1:0] cmd_len,
	// Write data, pulled one byte at a time
	input  wire logic [7:0]    wr_data,
	output logic               wr_take,
	// Read data
	output logic [7:0]         rd_data,
	output logic               rd_valid,
	// Completion
	output logic               done,
	output logic               done_nack,
	// Highest sample rate the chosen speed allows
	output logic [11:0]        rate_limit_hz
);
	import isra_pkg::*;

	isra_host_state_t st_q;       // Current bit-cell kind
	isra_step_t       step_q;     // Transfer phase
	logic [7:0]       qtim_q;     // Quarter cell timer
	logic [1:0]       q_q;        // Quarter within cell
	logic [3:0]       bit_q;      // Bit within byte
	logic [7:0]       sh_q;       // Byte shifter
	logic [LW-1:0]    rem_q;      // Data bytes left, minus one
	logic             read_q;     // Command is a read
	logic             fast_q;     // Command uses fast speed
	logic [7:0]       reg_q;      // Register to address
	logic             nack_q;     // Ack slot saw a nack
	logic             err_q;      // Transfer ended on a nack
	logic [7:0]       rdat_q;     // Read byte out
	logic             rval_q;     // Read byte strobe
	logic             done_q;     // Completion strobe
	logic             take_q;     // Write byte taken
	logic [11:0]      rate_q;     // Sample rate ceiling
	logic             sda_m_q;    // Data sync, first stage
	logic             sda_s_q;    // Data sync, second stage
	logic             scl_oe_n_q; // Registered clock enable
	logic             sda_oe_n_q; // Registered data enable
	logic             scl_lvl;    // Wanted clock level
	logic             sda_lvl;    // Wanted data level

	// Target address follows the strap we tie
	wire [6:0] dev_addr = STRAP_HIGH ? ADDR_STRAP_HI : ADDR_STRAP_LO;
	// Quarter length per speed; both keep the least low time
	wire [7:0] qtr_len  = fast_q ? QTR_FAST_CYC : QTR_STD_CYC; // RULE_05
	wire       busy     = st_q != HS_IDLE;
	wire       tick     = busy && qtim_q == 8'h00;
	wire       cell_end = tick && q_q == 2'h3;
	// Sample at the end of the second high quarter
	wire       sample   = tick && q_q == 2'h2;
	wire       in_ack   = bit_q == BIT_ACK;
	wire       last_rx  = rem_q == '0;
	wire       accept   = cmd_valid && !busy;

	// Line levels per cell kind; in data cells the clock is high in quarters 1 and 2
	always_comb begin
		scl_lvl = 1'b1;
		sda_lvl = 1'b1;
		unique case (st_q)
			HS_IDLE: ;
			HS_START: begin
				// Data falls while the clock is high; a fresh start keeps the clock up, so no short low pulse
				scl_lvl = (USE_RESTART && step_q == HP_ADDRR) ? (q_q[0] ^ q_q[1]) : (q_q != 2'h3); // RULE_05
				sda_lvl = ~q_q[1];
			end
			HS_STOP: begin
				// Data rises while the clock is high
				scl_lvl = |q_q;
				sda_lvl = q_q[1];
			end
			HS_TX: begin
				// Release the line for the slave ack
				scl_lvl = q_q[0] ^ q_q[1];
				sda_lvl = in_ack ? 1'b1 : sh_q[7];
			end
			HS_RX: begin
				// Ack each byte, nack the last one
				scl_lvl = q_q[0] ^ q_q[1];
				sda_lvl = in_ack ? last_rx : 1'b1; // RULE_08
			end
		endcase
	end

	// Data line synchroniser and registered pin enables
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_m_q    <= 1'b1;
			sda_s_q    <= 1'b1;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end else begin
			sda_m_q    <= bus.sda_i;
			sda_s_q    <= sda_m_q;
			scl_oe_n_q <= scl_lvl;
			sda_oe_n_q <= sda_lvl;
		end
	end

	// Quarter timer; zero after reset, holds qtr_len minus one between transfers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qtim_q <= 8'h00;
			q_q    <= 2'h0;
		end else if (accept) begin
			qtim_q <= cmd_fast ? QTR_FAST_CYC : QTR_STD_CYC;
			q_q    <= 2'h0;
		end else if (tick) begin
			qtim_q <= qtr_len - 8'h01;
			q_q    <= q_q + 2'h1;
		end else if (busy) begin
			qtim_q <= qtim_q - 8'h01;
		end
	end

	// Transfer sequencer, advanced at cell boundaries
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= HS_IDLE;
			step_q <= HP_END;
			bit_q  <= 4'h0;
			sh_q   <= 8'h00;
			rem_q  <= '0;
			read_q <= 1'b0;
			fast_q <= 1'b0;
			reg_q  <= 8'h00;
			nack_q <= 1'b0;
			err_q  <= 1'b0;
			rdat_q <= 8'h00;
			rval_q <= 1'b0;
			done_q <= 1'b0;
			take_q <= 1'b0;
			rate_q <= RATE_STD_HZ;
		end else begin
			rval_q <= 1'b0;
			done_q <= 1'b0;
			take_q <= 1'b0;
			if (accept) begin
				// Latch the command and open with a start
				st_q   <= HS_START;
				step_q <= HP_ADDRW;
				read_q <= cmd_read;
				fast_q <= cmd_fast;
				reg_q  <= cmd_reg;
				rem_q  <= cmd_len;
				err_q  <= 1'b0;
				rate_q <= cmd_fast ? RATE_FAST_HZ : RATE_STD_HZ; // RULE_09
			end
			if (sample && st_q == HS_TX && in_ack)
				nack_q <= sda_s_q;
			// Data is only looked at in ack slots while sending
			if (sample && st_q == HS_RX && !in_ack)
				sh_q <= {sh_q[6:0], sda_s_q}; // RULE_11
			if (cell_end) begin
				unique case (st_q)
					HS_IDLE: ;
					HS_START: begin
						st_q  <= HS_TX;
						bit_q <= 4'h0;
						sh_q  <= {dev_addr, (step_q == HP_ADDRR) ? RW_READ : RW_WRITE}; // RULE_07
					end
					HS_TX: begin
						if (!in_ack) begin
							bit_q <= bit_q + 4'h1;
							sh_q  <= {sh_q[6:0], 1'b0};
						end else if (nack_q) begin
							// Slave refused: give up with a stop
							bit_q  <= 4'h0;
							st_q   <= HS_STOP;
							step_q <= HP_END;
							err_q  <= 1'b1;
						end else begin
							bit_q <= 4'h0;
							unique case (step_q)
								HP_ADDRW: begin
									step_q <= HP_REG; // RULE_06
									sh_q   <= reg_q;
								end
								HP_REG: begin
									if (!read_q) begin
										step_q <= HP_WDATA;
										sh_q   <= wr_data;
										take_q <= 1'b1;
									end else if (USE_RESTART) begin
										st_q   <= HS_START; // RULE_10
										step_q <= HP_ADDRR;
									end else begin
										st_q   <= HS_STOP; // RULE_10
										step_q <= HP_MID;
									end
								end
								HP_WDATA: begin
									if (last_rx) begin
										st_q   <= HS_STOP;
										step_q <= HP_END;
									end else begin
										// Next byte goes to the next register
										rem_q  <= rem_q - 1'b1; // RULE_08
										sh_q   <= wr_data;
										take_q <= 1'b1;
									end
								end
								HP_ADDRR: begin
									st_q   <= HS_RX;
									step_q <= HP_RDATA;
								end
								default: begin
									st_q   <= HS_STOP;
									step_q <= HP_END;
								end
							endcase
						end
					end
					HS_RX: begin
						if (!in_ack) begin
							bit_q <= bit_q + 4'h1;
						end else begin
							// Hand out the byte after its ack slot
							bit_q  <= 4'h0;
							rdat_q <= sh_q;
							rval_q <= 1'b1;
							if (last_rx) begin
								st_q   <= HS_STOP;
								step_q <= HP_END;
							end else begin
								rem_q <= rem_q - 1'b1;
							end
						end
					end
					HS_STOP: begin
						if (step_q == HP_MID) begin
							st_q   <= HS_START;
							step_q <= HP_ADDRR;
						end else begin
							st_q   <= HS_IDLE;
							done_q <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	// Pins: open drain, and the straps tied firmly
	assign bus.host_scl_o           = 1'b0;
	assign bus.host_sda_o           = 1'b0;
	assign bus.host_scl_oe_n        = scl_oe_n_q;
	assign bus.host_sda_oe_n        = sda_oe_n_q;
	assign bus.chip_select          = 1'b1;       // RULE_01 RULE_04
	assign bus.address_select_strap = STRAP_HIGH; // RULE_04
	// User side
	assign cmd_ready                = !busy;
	assign wr_take                  = take_q;
	assign rd_data                  = rdat_q;
	assign rd_valid                 = rval_q;
	assign done                     = done_q;
	assign done_nack                = err_q;
	assign rate_limit_hz            = rate_q;
endmodule // isra_host

// File: logic/isra_pkg.sv
// Shared constants and types for the two-wire register port and its master
// Operation
// RULE_01: Port works while chip-select is held high
// RULE_02: Strap high answers slave address 0x1D
// RULE_03: Strap low answers alternate address 0x53
// RULE_04: Host ties strap and chip-select firmly
// RULE_05: Standard and fast bus speeds both work
// RULE_06: Write: address, register, data bytes, all acknowledged
// RULE_07: Read: set register, restart, device drives data
// RULE_08: Multi-byte transfers; master nacks last read byte
// RULE_09: Host keeps sample rate within bus limit
// RULE_10: Mid-read start may be restart or stop-start
// RULE_11: Master ignores device data while writing
// RULE_12: Register pointer advances after each data byte
package isra_pkg;
	// Clock of both ends
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Slave addresses for the two strap levels
	localparam logic [6:0]  ADDR_STRAP_HI = 7'h1D;
	localparam logic [6:0]  ADDR_STRAP_LO = 7'h53;
	localparam logic        RW_WRITE      = 1'b0;
	localparam logic        RW_READ       = 1'b1;
	// Bus speeds and the least fast-mode low time
	localparam int unsigned F_STD_KHZ     = 100;
	localparam int unsigned F_FAST_KHZ    = 400;
	localparam int unsigned T_LOW_FAST_NS = 1300;
	// Quarter bit cell in clock cycles, rounded up
	localparam logic [7:0]  QTR_STD_CYC   = 8'((1000000 / (F_STD_KHZ * 4) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0]  QTR_FAST_CYC  = 8'((T_LOW_FAST_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Highest sample rate per bus speed, scaled linearly
	localparam int unsigned RATE_MAX_FAST = 800;
	localparam logic [11:0] RATE_FAST_HZ  = 12'(RATE_MAX_FAST);
	localparam logic [11:0] RATE_STD_HZ   = 12'(RATE_MAX_FAST * F_STD_KHZ / F_FAST_KHZ);
	// Bit counter codes
	localparam logic [3:0]  BIT_PRE       = 4'hF;
	localparam logic [3:0]  BIT_LAST      = 4'h7;
	localparam logic [3:0]  BIT_ACK       = 4'h8;
	// Device protocol states
	typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_PTR, DS_WDATA, DS_RDATA} isra_dev_state_t;
	// Host bit-cell kinds
	typedef enum logic [2:0] {HS_IDLE, HS_START, HS_TX, HS_RX, HS_STOP} isra_host_state_t;
	// Host transfer phases
	typedef enum logic [2:0] {HP_ADDRW, HP_REG, HP_WDATA, HP_MID, HP_ADDRR, HP_RDATA, HP_END} isra_step_t;
endpackage

// File: logic/isra_bus_if.sv
// Two-wire bus with open-drain resolution and the strap pins
`timescale 1ns/100ps
interface isra_bus_if;
	logic host_scl_o;           // Host clock drive level
	logic host_scl_oe_n;        // Host clock enable, low drives
	logic host_sda_o;           // Host data drive level
	logic host_sda_oe_n;        // Host data enable, low drives
	logic dev_sda_o;            // Device data drive level
	logic dev_sda_oe_n;         // Device data enable, low drives
	logic chip_select;          // Port select, high for this bus
	logic address_select_strap; // Slave address strap
	logic scl_i;                // Resolved clock line
	logic sda_i;                // Resolved data line
	// Pull-up: a line is low only where someone drives low
	assign scl_i = host_scl_oe_n | host_scl_o;
	assign sda_i = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
	modport host (
		output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n, chip_select, address_select_strap,
		input  scl_i, sda_i
	);
	modport dev (
		output dev_sda_o, dev_sda_oe_n,
		input  scl_i, sda_i, chip_select, address_select_strap
	);
endinterface // isra_bus_if

// File: logic/isra_device.sv
// Slave end: serial register port of the sensor
`timescale 1ns/100ps
module isra_device (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Bus pins
	isra_bus_if.dev         bus,
	// Register file side
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	import isra_pkg::*;

	logic            scl_m_q, scl_s_q, scl_p_q;   // Clock sync chain
	logic            sda_m_q, sda_s_q, sda_p_q;   // Data sync chain
	logic            cs_m_q, cs_s_q;              // Chip-select sync
	logic            stp_m_q, stp_s_q;            // Strap sync
	isra_dev_state_t st_q;                        // Protocol state
	logic [3:0]      bit_q;                       // Bit in byte
	logic [7:0]      sh_q;                        // Receive shifter
	logic [7:0]      tx_q;                        // Transmit shifter
	logic [7:0]      ptr_q;                       // Register pointer
	logic [7:0]      addr_q, wdat_q;              // Access outputs
	logic            wr_q, rd_q;                  // Access strobes
	logic            rw_q;                        // Direction bit
	logic            oe_n_q;                      // Data line enable

	// Edge and condition decode on the synced lines
	wire       scl_rise  = scl_s_q & ~scl_p_q;
	wire       scl_fall  = ~scl_s_q & scl_p_q;
	wire       start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	wire       stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	wire [6:0] my_addr   = stp_s_q ? ADDR_STRAP_HI : ADDR_STRAP_LO; // RULE_02 RULE_03
	wire       addr_hit  = sh_q[7:1] == my_addr;
	wire       in_ack    = bit_q == BIT_ACK;
	wire       last_bit  = bit_q == BIT_LAST;

	// Pin synchronisers; pins come from outside the clock domain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
			{cs_m_q, cs_s_q}            <= 2'h0;
			{stp_m_q, stp_s_q}          <= 2'h0;
		end else begin
			{scl_m_q, scl_s_q, scl_p_q} <= {bus.scl_i, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {bus.sda_i, sda_m_q, sda_s_q};
			{cs_m_q, cs_s_q}            <= {bus.chip_select, cs_m_q};
			{stp_m_q, stp_s_q}          <= {bus.address_select_strap, stp_m_q};
		end
	end

	// Protocol engine, stepped by bus edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= DS_IDLE;
			bit_q  <= BIT_PRE;
			sh_q   <= 8'h00;
			tx_q   <= 8'h00;
			ptr_q  <= 8'h00;
			addr_q <= 8'h00;
			wdat_q <= 8'h00;
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			rw_q   <= RW_WRITE;
			oe_n_q <= 1'b1;
		end else begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			if (!cs_s_q || stop_det) begin // RULE_01
				// Deselected or stopped: release the line
				st_q   <= DS_IDLE;
				oe_n_q <= 1'b1;
			end else if (start_det) begin
				// Start or repeated start both reopen addressing
				st_q   <= DS_ADDR;
				bit_q  <= BIT_PRE;
				oe_n_q <= 1'b1;
			end else if (scl_rise) begin
				// Sample data while the clock is high
				if (bit_q < BIT_ACK && st_q != DS_RDATA)
					sh_q <= {sh_q[6:0], sda_s_q};
				if (st_q == DS_RDATA && in_ack) begin
					if (sda_s_q) begin
						// Master nack ends the read
						st_q <= DS_IDLE; // RULE_08
					end else begin
						// Ack: fetch the next register
						rd_q   <= 1'b1;
						addr_q <= ptr_q;
						ptr_q  <= ptr_q + 8'h01; // RULE_12
					end
				end
			end else if (scl_fall && st_q != DS_IDLE) begin
				// Data changes only while the clock is low
				bit_q <= (in_ack || bit_q == BIT_PRE) ? 4'h0 : bit_q + 4'h1;
				unique case (st_q)
					DS_ADDR: begin
						if (last_bit && bit_q != BIT_PRE) begin
							if (addr_hit) begin
								oe_n_q <= 1'b0;
								rw_q   <= sh_q[0];
								if (sh_q[0] == RW_READ) begin
									// Prefetch the first read byte during the ack
									rd_q   <= 1'b1;
									addr_q <= ptr_q;
									ptr_q  <= ptr_q + 8'h01; // RULE_12
								end
							end else begin
								// Another slave is addressed
								st_q <= DS_IDLE;
							end
						end else if (in_ack) begin
							if (rw_q == RW_READ) begin
								st_q   <= DS_RDATA; // RULE_07
								tx_q   <= {reg_rdata[6:0], 1'b0};
								oe_n_q <= reg_rdata[7];
							end else begin
								st_q   <= DS_PTR;
								oe_n_q <= 1'b1;
							end
						end
					end
					DS_PTR: begin
						if (last_bit) begin
							oe_n_q <= 1'b0; // RULE_06
							ptr_q  <= sh_q;
						end else if (in_ack) begin
							oe_n_q <= 1'b1;
							st_q   <= DS_WDATA;
						end
					end
					DS_WDATA: begin
						if (last_bit) begin
							// Ack and commit each written byte
							oe_n_q <= 1'b0; // RULE_06
							wr_q   <= 1'b1;
							wdat_q <= sh_q;
							addr_q <= ptr_q;
							ptr_q  <= ptr_q + 8'h01; // RULE_12
						end else if (in_ack) begin
							oe_n_q <= 1'b1;
						end
					end
					DS_RDATA: begin
						if (in_ack) begin
							// Next byte was fetched at the master ack
							tx_q   <= {reg_rdata[6:0], 1'b0}; // RULE_08
							oe_n_q <= reg_rdata[7];
						end else if (last_bit) begin
							// Leave the ack slot to the master
							oe_n_q <= 1'b1;
						end else begin
							oe_n_q <= tx_q[7];
							tx_q   <= {tx_q[6:0], 1'b0};
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Open drain: only low is ever driven
	assign bus.dev_sda_o    = 1'b0;
	assign bus.dev_sda_oe_n = oe_n_q;
	assign reg_addr         = addr_q;
	assign reg_wdata        = wdat_q;
	assign reg_wr           = wr_q;
	assign reg_rd           = rd_q;
endmodule // isra_device

// File: verification/isra_bus_checker.sv
// Bus-level checks between the host end and the device end
`timescale 1ns/100ps
module isra_bus_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Drive levels and device enable
	input wire logic host_scl_o,
	input wire logic host_sda_o,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	// Straps and resolved lines
	input wire logic chip_select,
	input wire logic address_select_strap,
	input wire logic scl_i,
	input wire logic sda_i
);
	import isra_pkg::*;
	// Least clock low and high times in cycles, slack for the edge lag
	localparam int LOW_MIN  = 128;
	localparam int HIGH_MIN = 58;
	logic       scl_q;                  // Clock line one cycle back
	logic [7:0] low_q, low_d;           // Cycles clock low, saturating
	logic [7:0] high_q, high_d;         // Cycles clock high, saturating
	logic [7:0] fall_q, fall_d;         // Cycles since last clock fall
	wire        scl_fell = scl_q & ~scl_i;
	// Saturation keeps standard mode from wrapping the counts
	assign low_d  = scl_i ? 8'h00 : (low_q == 8'hFF ? low_q : low_q + 8'h01);
	assign high_d = !scl_i ? 8'h00 : (high_q == 8'hFF ? high_q : high_q + 8'h01);
	assign fall_d = scl_fell ? 8'h00 : (fall_q == 8'hFF ? fall_q : fall_q + 8'h01);
	// Counter registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q  <= 1'b1;
			low_q  <= 8'h00;
			high_q <= 8'h00;
			fall_q <= 8'hFF;
		end else begin
			scl_q  <= scl_i;
			low_q  <= low_d;
			high_q <= high_d;
			fall_q <= fall_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_CS_HIGH: assert property (chip_select) else $error("chip select dropped");
	AST_STRAP_STABLE: assert property ($stable(address_select_strap)) else $error("strap moved");
	AST_OPEN_DRAIN: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
		else $error("a line is driven high");
	AST_SCL_LOW_TIME: assert property ($rose(scl_i) |-> low_q >= LOW_MIN) else $error("clock low too short");
	AST_SCL_HIGH_TIME: assert property ($fell(scl_i) |-> high_q >= HIGH_MIN)
		else $error("clock high too short");
	AST_DEV_AFTER_FALL: assert property (dev_sda_oe_n != $past(dev_sda_oe_n) |-> !scl_i && fall_q <= 6)
		else $error("device moved data outside the low phase");
	AST_DEV_ACK_HOLD: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
		else $error("device released data too soon");
	AST_DEV_NO_START: assert property (scl_q && scl_i && $fell(sda_i) |-> dev_sda_oe_n [*8])
		else $error("device drove data during a start");
endmodule // isra_bus_checker

// File: verification/testbench.sv
// Self-checking bench: two host and device pairs, one for each strap level
`timescale 1ns/100ps
module testbench;
	import isra_pkg::*;
	logic        clk = 1'b0;     // System clock
	logic        rst_n = 1'b0;   // Async reset, active low
	// Per-pair command, result and register-side signals
	logic        cmd_valid[2], cmd_read[2], cmd_fast[2], cmd_ready[2], wr_take[2];
	logic        rd_valid[2], done[2], done_nack[2], reg_wr[2], reg_rd[2];
	logic [7:0]  cmd_reg[2], wr_data[2], rd_data[2], reg_addr[2], reg_wdata[2], reg_rdata[2];
	logic [3:0]  cmd_len[2];
	logic [11:0] rate[2];
	// Register files, reference model, write bytes and monitor state
	logic [7:0]  rf[2][256], em[2][256], wbuf[2][16], base[2];
	logic [8:0]  sh[2];
	logic        scl[2], sda[2], scl_p[2], sda_p[2];
	int          wi[2], rc[2], wc[2], rr[2], nst[2], nb[2], sel_rd[2], first[2];
	int          n_errors = 0, samples_checked = 0;
	isra_bus_if bus_a();
	isra_bus_if bus_b();
	assign scl[0] = bus_a.scl_i;
	assign sda[0] = bus_a.sda_i;
	assign scl[1] = bus_b.scl_i;
	assign sda[1] = bus_b.sda_i;
	// Pair A: strap high with restart; pair B: strap low with stop then start
	isra_host #(.STRAP_HIGH(1'b1), .USE_RESTART(1'b1)) u_isra_host (.clk(clk), .rst_n(rst_n), .bus(bus_a),
		.cmd_valid(cmd_valid[0]), .cmd_ready(cmd_ready[0]), .cmd_read(cmd_read[0]), .cmd_fast(cmd_fast[0]),
		.cmd_reg(cmd_reg[0]), .cmd_len(cmd_len[0]), .wr_data(wr_data[0]), .wr_take(wr_take[0]),
		.rd_data(rd_data[0]), .rd_valid(rd_valid[0]), .done(done[0]), .done_nack(done_nack[0]), .rate_limit_hz(rate[0]));
	isra_device u_isra_device (.clk(clk), .rst_n(rst_n), .bus(bus_a), .reg_addr(reg_addr[0]),
		.reg_wdata(reg_wdata[0]), .reg_wr(reg_wr[0]), .reg_rd(reg_rd[0]), .reg_rdata(reg_rdata[0]));
	isra_host #(.STRAP_HIGH(1'b0), .USE_RESTART(1'b0)) u_isra_host_alt (.clk(clk), .rst_n(rst_n), .bus(bus_b),
		.cmd_valid(cmd_valid[1]), .cmd_ready(cmd_ready[1]), .cmd_read(cmd_read[1]), .cmd_fast(cmd_fast[1]),
		.cmd_reg(cmd_reg[1]), .cmd_len(cmd_len[1]), .wr_data(wr_data[1]), .wr_take(wr_take[1]),
		.rd_data(rd_data[1]), .rd_valid(rd_valid[1]), .done(done[1]), .done_nack(done_nack[1]), .rate_limit_hz(rate[1]));
	isra_device u_isra_device_alt (.clk(clk), .rst_n(rst_n), .bus(bus_b), .reg_addr(reg_addr[1]),
		.reg_wdata(reg_wdata[1]), .reg_wr(reg_wr[1]), .reg_rd(reg_rd[1]), .reg_rdata(reg_rdata[1]));
	// Checker watches pair A only
	isra_bus_checker u_isra_bus_checker (.clk(clk), .rst_n(rst_n), .host_scl_o(bus_a.host_scl_o),
		.host_sda_o(bus_a.host_sda_o), .dev_sda_o(bus_a.dev_sda_o), .dev_sda_oe_n(bus_a.dev_sda_oe_n),
		.chip_select(bus_a.chip_select), .address_select_strap(bus_a.address_select_strap),
		.scl_i(bus_a.scl_i), .sda_i(bus_a.sda_i));
	// Free-running clock
	always #5 clk = ~clk;
	// Byte comparison
	task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Status, count and wire comparison
	task automatic chk_stat(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// One command on pair p: n data bytes from register r
	task automatic run(input int p, input bit rd, input bit fast, input logic [7:0] r, input int n);
		int t;
		for (int i = 0; i < n; i++) wbuf[p][i] = 8'($urandom);
		base[p] = r; wi[p] = 0; rc[p] = 0; wc[p] = 0; rr[p] = 0; nst[p] = 0; sel_rd[p] = int'(rd);
		cmd_valid[p] <= 1'b1; cmd_read[p] <= rd; cmd_fast[p] <= fast;
		cmd_reg[p] <= r; cmd_len[p] <= 4'(n - 1); wr_data[p] <= wbuf[p][0];
		@(posedge clk);
		cmd_valid[p] <= 1'b0;
		@(negedge clk);
		chk_stat(16'(cmd_ready[p]), 16'h0000);
		t = 0;
		// Bounded wait: the longest transfer is well under this
		while (done[p] !== 1'b1 && t < 60000) begin
			@(negedge clk);
			t++;
		end
		if (t >= 60000) n_errors++;
		chk_stat(16'(done_nack[p]), 16'h0000);
		chk_stat(16'(rd ? rc[p] : wc[p]), 16'(n));
		chk_stat(16'(rate[p]), fast ? 16'h0320 : 16'h00C8);
		if (!rd) for (int i = 0; i < n; i++) em[p][8'(r + i)] = wbuf[p][i];
		@(posedge clk);
	endtask
	// Register files, write-byte feed, result checks and wire monitor
	always @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			if (reg_wr[p]) begin
				rf[p][reg_addr[p]] <= reg_wdata[p];
				chk_data(reg_addr[p], 8'(base[p] + wc[p]));
				chk_data(reg_wdata[p], wbuf[p][wc[p]]);
				wc[p]++;
			end
			if (reg_rd[p]) begin
				reg_rdata[p] <= rf[p][reg_addr[p]];
				chk_data(reg_addr[p], 8'(base[p] + rr[p]));
				rr[p]++;
			end
			if (rd_valid[p]) begin
				chk_data(rd_data[p], em[p][8'(base[p] + rc[p])]);
				rc[p]++;
			end
			if (wr_take[p] && wi[p] < 15) begin
				wi[p]++;
				wr_data[p] <= wbuf[p][wi[p]];
			end
			scl_p[p] <= scl[p];
			sda_p[p] <= sda[p];
			// Start seen: data falls while the clock stays high
			if (scl_p[p] && scl[p] && sda_p[p] && !sda[p]) begin
				nst[p]++;
				nb[p] = 0;
				first[p] = 1;
			end else if (!scl_p[p] && scl[p]) begin
				sh[p] = {sh[p][7:0], sda[p]};
				nb[p]++;
				if (nb[p] == 9 && first[p] != 0) begin
					first[p] = 0;
					chk_stat(16'(sh[p]), 16'({p ? ADDR_STRAP_LO : ADDR_STRAP_HI, sel_rd[p] != 0 && nst[p] == 2, 1'b0}));
				end
			end
		end
	end
	// Watchdog: about twice the expected run time
	initial begin
		#1000000;
		n_errors++;
		final_report();
	end
	// Main sequence
	initial begin
		void'($urandom(49));
		for (int p = 0; p < 2; p++) begin
			cmd_valid[p] = 1'b0; cmd_read[p] = 1'b0; cmd_fast[p] = 1'b0; cmd_reg[p] = 8'h00;
			cmd_len[p] = 4'h0; wr_data[p] = 8'h00; reg_rdata[p] = 8'h00; scl_p[p] = 1'b1; sda_p[p] = 1'b1;
			sh[p] = 9'h000; nb[p] = 0; first[p] = 0; base[p] = 8'h00; wi[p] = 0; wc[p] = 0; rc[p] = 0; rr[p] = 0;
			for (int i = 0; i < 256; i++) begin
				rf[p][i] = 8'($urandom);
				em[p][i] = rf[p][i];
			end
		end
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		fork
			begin
				run(0, 1'b0, 1'b1, 8'hFE, 5);
				run(0, 1'b1, 1'b1, 8'hFE, 5);
				run(0, 1'b1, 1'b1, 8'h01, 1);
			end
			begin
				run(1, 1'b0, 1'b0, 8'h41, 1);
				run(1, 1'b1, 1'b1, 8'h40, 2);
			end
		join
		final_report();
	end
endmodule // testbench
